//--- pfs_pkg.sv
// constants and carrier types for the port pin function select block
package pfs_pkg;

  // register bus geometry, pin count and interrupt line count
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NPIN = 4;
  localparam int unsigned NINT = 3;

  // register offset of the port function mode register
  localparam logic [ADDR_W-1:0] PORT_FUNCTION_MODE_1_OFFSET = 4'h0;

  // field positions in the port function mode register
  localparam int unsigned BIT_EXT_INT_LINE_TWO_SEL = 6;
  localparam int unsigned BIT_EXT_INT_LINE_ONE_SEL = 5;
  localparam int unsigned BIT_EXT_INT_LINE_ZERO_SEL = 4;
  localparam int unsigned BIT_RSV_HI = 3;
  localparam int unsigned BIT_RSV_LO = 2;
  localparam int unsigned BIT_TXD_SEL = 1;

  // reserved bits read as ones
  localparam logic [DATA_W-1:0] RSV_READ_MASK = 8'h0c;

  // pin index inside the select vector
  localparam int unsigned IDX_PORT1_PIN4 = 0;
  localparam int unsigned IDX_PORT1_PIN5 = 1;
  localparam int unsigned IDX_PORT1_PIN6 = 2;
  localparam int unsigned IDX_PORT2_PIN2 = 3;

  // values after reset
  localparam logic [NPIN-1:0] SEL_RESET = 4'h0;
  localparam logic [DATA_W-1:0] RDATA_RESET = 8'h00;
  localparam logic [NPIN-1:0] PIN_OUT_RESET = 4'h0;
  localparam logic [NPIN-1:0] PIN_OEN_RESET = 4'hf;
  localparam logic [NPIN-1:0] GPIO_IN_RESET = 4'h0;
  localparam logic [NINT-1:0] INT_N_RESET = 3'h7;
  localparam logic [1:0] RST_PIPE_RESET = 2'h0;
  localparam logic [NPIN-1:0] SYNC_RESET = 4'h0;

  // register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pfs_bus_req_t;

  // drive request for a group of pins: data and enable per pin
  typedef struct packed {
    logic [NPIN-1:0] data;
    logic [NPIN-1:0] en;
  } pfs_drive_t;

  // pad side of a group of pins
  typedef struct packed {
    logic [NPIN-1:0] out;
    logic [NPIN-1:0] oeN;
  } pfs_pad_t;

  // state of the synchroniser
  typedef struct packed {
    logic [NPIN-1:0] stage1;
    logic [NPIN-1:0] stage2;
  } pfs_sync_state_t;

  // state of the top module
  typedef struct packed {
    logic [NPIN-1:0] sel;
    logic [DATA_W-1:0] rdata;
    pfs_pad_t pad;
    logic [NPIN-1:0] gpioIn;
    logic [NINT-1:0] extIntN;
  } pfs_state_t;

endpackage

//--- pfs_port_func_sel.sv
// port pin function select: mode register and pin multiplexer
//
// Notes on behaviour
// - mode bit 6 set makes port1_pin6 the interrupt input two, clear leaves it plain I/O.
// - mode bit 5 set makes port1_pin5 the interrupt input one, clear leaves it plain I/O.
// - mode bit 4 set makes port1_pin4 the interrupt input zero, clear leaves it plain I/O.
// - mode bit 1 set makes port2_pin2 drive serial transmit data, clear leaves it plain I/O.
// - mode bits 3 and 2 always read back as one, whatever was written.
// - mode bits 6, 5, 4 and 1 are read and written and clear to zero at reset.
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module pfs_port_func_sel (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire pfs_pkg::pfs_bus_req_t busReq,
  output logic [pfs_pkg::DATA_W-1:0] busRdata,
  // port data path requests, index 0..2 port1 pins 4..6, index 3 port2 pin2
  input wire pfs_pkg::pfs_drive_t gpioDrive,
  output logic [pfs_pkg::NPIN-1:0] gpioIn,
  // serial unit transmit data
  input wire logic serialTxData,
  // interrupt controller request lines, active low, index 0..2 line zero..two
  output logic [pfs_pkg::NINT-1:0] extIntN,
  // pads
  input wire logic [pfs_pkg::NPIN-1:0] pinIn,
  output pfs_pkg::pfs_pad_t pinPad
);

  // register hit decode
  function automatic logic pfs_hit(input logic [pfs_pkg::ADDR_W-1:0] addr);
    pfs_hit = (addr == pfs_pkg::PORT_FUNCTION_MODE_1_OFFSET);
  endfunction

  // mode register image to select vector
  function automatic logic [pfs_pkg::NPIN-1:0] pfs_to_sel(
    input logic [pfs_pkg::DATA_W-1:0] img
  );
    logic [pfs_pkg::NPIN-1:0] s;
    s = pfs_pkg::SEL_RESET;
    s[pfs_pkg::IDX_PORT1_PIN6] = img[pfs_pkg::BIT_EXT_INT_LINE_TWO_SEL];
    s[pfs_pkg::IDX_PORT1_PIN5] = img[pfs_pkg::BIT_EXT_INT_LINE_ONE_SEL];
    s[pfs_pkg::IDX_PORT1_PIN4] = img[pfs_pkg::BIT_EXT_INT_LINE_ZERO_SEL];
    s[pfs_pkg::IDX_PORT2_PIN2] = img[pfs_pkg::BIT_TXD_SEL];
    pfs_to_sel = s;
  endfunction

  // select vector to mode register image
  function automatic logic [pfs_pkg::DATA_W-1:0] pfs_to_img(
    input logic [pfs_pkg::NPIN-1:0] s
  );
    logic [pfs_pkg::DATA_W-1:0] img;
    img = pfs_pkg::RSV_READ_MASK;
    img[pfs_pkg::BIT_EXT_INT_LINE_TWO_SEL] = s[pfs_pkg::IDX_PORT1_PIN6];
    img[pfs_pkg::BIT_EXT_INT_LINE_ONE_SEL] = s[pfs_pkg::IDX_PORT1_PIN5];
    img[pfs_pkg::BIT_EXT_INT_LINE_ZERO_SEL] = s[pfs_pkg::IDX_PORT1_PIN4];
    img[pfs_pkg::BIT_TXD_SEL] = s[pfs_pkg::IDX_PORT2_PIN2];
    pfs_to_img = img;
  endfunction

  // reset release through two flip-flops
  logic [1:0] rstPipe_reg;
  logic rstSyncN;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstPipe_reg <= pfs_pkg::RST_PIPE_RESET;
    end
    else
    begin
      rstPipe_reg <= {rstPipe_reg[0], 1'b1};
    end
  end

  assign rstSyncN = rstPipe_reg[1];

  // pad inputs pass two flip-flops
  logic [pfs_pkg::NPIN-1:0] pinSync;

  pfs_sync u_sync (
    .clk(clk),
    .rstSyncN(rstSyncN),
    .d(pinIn),
    .q(pinSync)
  );

  pfs_pkg::pfs_state_t state_reg;
  pfs_pkg::pfs_state_t state_next;

  // per-pin multiplexer for the three interrupt-capable port 1 pins
  logic [pfs_pkg::NINT-1:0] muxOut;
  logic [pfs_pkg::NINT-1:0] muxOeN;
  logic [pfs_pkg::NINT-1:0] muxIntN;

  genvar gi;
  generate
    for (gi = 0; gi < pfs_pkg::NINT; gi = gi + 1)
    begin : g_port1
      always_comb
      begin
        if (state_reg.sel[gi])
        begin
          // interrupt input: pad released, level forwarded
          muxOut[gi] = 1'b0;
          muxOeN[gi] = 1'b1;
          muxIntN[gi] = pinSync[gi];
        end
        else
        begin
          // plain I/O: port data path owns the pad
          muxOut[gi] = gpioDrive.data[gi];
          muxOeN[gi] = ~gpioDrive.en[gi];
          muxIntN[gi] = 1'b1;
        end
      end
    end
  endgenerate

  // port 2 pin 2 multiplexer
  logic txOut;
  logic txOeN;

  always_comb
  begin
    if (state_reg.sel[pfs_pkg::IDX_PORT2_PIN2])
    begin
      // transmit data output, always driven
      txOut = serialTxData;
      txOeN = 1'b0;
    end
    else
    begin
      txOut = gpioDrive.data[pfs_pkg::IDX_PORT2_PIN2];
      txOeN = ~gpioDrive.en[pfs_pkg::IDX_PORT2_PIN2];
    end
  end

  // next state
  always_comb
  begin
    state_next = state_reg;

    // register write, reserved positions dropped
    if (busReq.wr && pfs_hit(busReq.addr))
    begin
      state_next.sel = pfs_to_sel(busReq.wdata);
    end

    // read data stands for one cycle only
    if (busReq.rd && pfs_hit(busReq.addr))
    begin
      state_next.rdata = pfs_to_img(state_reg.sel);
    end
    else
    begin
      state_next.rdata = pfs_pkg::RDATA_RESET;
    end

    // pads
    state_next.pad.out[pfs_pkg::NINT-1:0] = muxOut;
    state_next.pad.oeN[pfs_pkg::NINT-1:0] = muxOeN;
    state_next.pad.out[pfs_pkg::IDX_PORT2_PIN2] = txOut;
    state_next.pad.oeN[pfs_pkg::IDX_PORT2_PIN2] = txOeN;

    // pad levels back to the port data path
    state_next.gpioIn = pinSync;

    // interrupt request lines
    state_next.extIntN = muxIntN;
  end

  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      state_reg.sel <= pfs_pkg::SEL_RESET;
      state_reg.rdata <= pfs_pkg::RDATA_RESET;
      state_reg.pad.out <= pfs_pkg::PIN_OUT_RESET;
      state_reg.pad.oeN <= pfs_pkg::PIN_OEN_RESET;
      state_reg.gpioIn <= pfs_pkg::GPIO_IN_RESET;
      state_reg.extIntN <= pfs_pkg::INT_N_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // outputs straight from flip-flops
  assign busRdata = state_reg.rdata;
  assign gpioIn = state_reg.gpioIn;
  assign extIntN = state_reg.extIntN;
  assign pinPad = state_reg.pad;

endmodule

`default_nettype wire

//--- pfs_port_func_sel_sva.sv
// assertion checker for the port pin function select block
`timescale 1ns/1ps
`default_nettype none

module pfs_port_func_sel_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire pfs_pkg::pfs_bus_req_t busReq,
  input wire logic [pfs_pkg::DATA_W-1:0] busRdata,
  // pin side
  input wire pfs_pkg::pfs_drive_t gpioDrive,
  input wire logic [pfs_pkg::NPIN-1:0] gpioIn,
  input wire logic serialTxData,
  input wire logic [pfs_pkg::NINT-1:0] extIntN,
  input wire logic [pfs_pkg::NPIN-1:0] pinIn,
  input wire pfs_pkg::pfs_pad_t pinPad
);
  logic [1:0] upCnt;
  logic [7:0] selSh;
  logic live;
  assign live = upCnt == 2'h3;
  // shadow of the select bits, live once reset has left the design
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      upCnt <= 2'h0;
      selSh <= 8'h00;
    end
    else
    begin
      if (!live) upCnt <= upCnt + 2'h1;
      if (busReq.wr && busReq.addr == 4'h0) selSh <= busReq.wdata & 8'h72;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence rdReg;
    live && busReq.rd && busReq.addr == 4'h0;
  endsequence
  sequence pin6Low;
    live && selSh[6] && !pinIn[2] ##1 selSh[6] && !pinIn[2] ##1 selSh[6] && !pinIn[2];
  endsequence
  sequence rsvWrite;
    live && busReq.wr && busReq.addr == 4'h0 && busReq.wdata == 8'h0c;
  endsequence
  sequence pin5High;
    live && selSh[5] && pinIn[1] ##1 selSh[5] && pinIn[1] ##1 selSh[5] && pinIn[1];
  endsequence
  AST_PIN6_INT: assert property (live && selSh[6] |=> pinPad.oeN[2] && !pinPad.out[2])
    else $error("pin6 still driven");
  AST_PIN6_GPIO: assert property (live && !selSh[6] |=> pinPad.oeN[2] == !$past(gpioDrive.en[2]))
    else $error("pin6 enable wrong");
  AST_PIN6_REQ: assert property (pin6Low |=> !extIntN[2])
    else $error("line two not low");
  AST_PIN5_INT: assert property (live && selSh[5] |=> pinPad.oeN[1] && !pinPad.out[1])
    else $error("pin5 still driven");
  AST_PIN4_IDLE: assert property (live && !selSh[4] |=> extIntN[0])
    else $error("line zero active");
  AST_TXD: assert property (live && selSh[1] |=> !pinPad.oeN[3] && pinPad.out[3] == $past(serialTxData))
    else $error("txd not driven");
  AST_RSV: assert property (rdReg |=> busRdata[3:2] == 2'h3)
    else $error("reserved bits not one");
  AST_RDBK: assert property (rdReg |=> busRdata == ($past(selSh) | 8'h0c))
    else $error("readback wrong");
  AST_RSV_WR: assert property (rsvWrite ##1 rdReg |=> busRdata == 8'h0c)
    else $error("reserved write took effect");
  AST_PIN5_REQ: assert property (pin5High |=> extIntN[1])
    else $error("line one not high");
  AST_RD_IDLE: assert property (live && !busReq.rd |=> busRdata == 8'h00)
    else $error("read data not cleared");
endmodule

bind pfs_port_func_sel pfs_port_func_sel_sva u_pfs_port_func_sel_sva (
  .clk(clk),
  .rst_n(rst_n),
  .busReq(busReq),
  .busRdata(busRdata),
  .gpioDrive(gpioDrive),
  .gpioIn(gpioIn),
  .serialTxData(serialTxData),
  .extIntN(extIntN),
  .pinIn(pinIn),
  .pinPad(pinPad)
);

`default_nettype wire

//--- pfs_port_func_sel_tb_top.sv
// testbench for the port pin function select block
`timescale 1ns/1ps
`default_nettype none

module pfs_port_func_sel_tb_top;
  logic clk;
  logic rst_n;
  pfs_pkg::pfs_bus_req_t busReq;
  logic [7:0] busRdata;
  pfs_pkg::pfs_drive_t gpioDrive;
  logic [3:0] gpioIn;
  logic serialTxData;
  logic [2:0] extIntN;
  logic [3:0] pinIn;
  pfs_pkg::pfs_pad_t pinPad;
  int mismatches;
  int nChecks;
  int bitPos[4] = '{6, 5, 4, 1};

  pfs_port_func_sel u_pfs_port_func_sel (
    .clk(clk),
    .rst_n(rst_n),
    .busReq(busReq),
    .busRdata(busRdata),
    .gpioDrive(gpioDrive),
    .gpioIn(gpioIn),
    .serialTxData(serialTxData),
    .extIntN(extIntN),
    .pinIn(pinIn),
    .pinPad(pinPad)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    busReq.wr <= 1'b1;
    busReq.addr <= a;
    busReq.wdata <= d;
    @(posedge clk);
    busReq.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    busReq.rd <= 1'b1;
    busReq.addr <= a;
    @(posedge clk);
    busReq.rd <= 1'b0;
    @(negedge clk);
    chk(busRdata, exp);
    @(posedge clk);
  endtask

  initial
  begin
    repeat (2000) @(posedge clk);
    mismatches++;
    summarize();
  end

  initial
  begin
    int b;
    int idx;
    rst_n = 1'b0;
    busReq = '0;
    gpioDrive = '0;
    serialTxData = 1'b0;
    pinIn = 4'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(4'h0, 8'h0c);
    @(negedge clk);
    chk({4'h0, pinPad.oeN}, 8'h0f);
    @(posedge clk);
    rd(4'h5, 8'h00);
    wr(4'h0, 8'hff);
    rd(4'h0, 8'h7e);
    wr(4'h0, 8'h0c);
    rd(4'h0, 8'h0c);
    gpioDrive <= '{data: 4'hf, en: 4'hf};
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({4'h0, pinPad.oeN}, 8'h00);
    @(posedge clk);
    for (int i = 0; i < 4; i++)
    begin
      b = bitPos[i];
      idx = (b == 1) ? 3 : b - 4;
      wr(4'h0, 8'h01 << b);
      rd(4'h0, (8'h01 << b) | 8'h0c);
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk({4'h0, pinPad.out}, 8'h0f & ~(8'h01 << idx));
      chk({4'h0, pinPad.oeN}, (b == 1) ? 8'h00 : (8'h01 << idx));
      chk({5'h00, extIntN}, (b == 1) ? 8'h07 : 8'h07 & ~(8'h01 << idx));
      chk({4'h0, gpioIn}, 8'h00);
      @(posedge clk);
    end
    serialTxData <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({7'h00, pinPad.out[3]}, 8'h01);
    @(posedge clk);
    wr(4'h0, 8'h72);
    pinIn <= 4'hb;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk({5'h00, extIntN}, 8'h03);
    chk({4'h0, gpioIn}, 8'h0b);
    chk({4'h0, pinPad.oeN}, 8'h07);
    chk({4'h0, pinPad.out}, 8'h08);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(4'h0, 8'h0c);
    @(negedge clk);
    chk({5'h00, extIntN}, 8'h07);
    summarize();
  end
endmodule

`default_nettype wire

//--- pfs_sync.sv
// two flip-flop synchroniser for the pin inputs
`timescale 1ns/1ps
`default_nettype none

module pfs_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rstSyncN,
  // asynchronous levels in, synchronised levels out
  input wire logic [pfs_pkg::NPIN-1:0] d,
  output logic [pfs_pkg::NPIN-1:0] q
);

  pfs_pkg::pfs_sync_state_t state_reg;
  pfs_pkg::pfs_sync_state_t state_next;

  // first stage feeds only the second stage
  always_comb
  begin
    state_next = state_reg;
    state_next.stage1 = d;
    state_next.stage2 = state_reg.stage1;
  end

  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      state_reg.stage1 <= pfs_pkg::SYNC_RESET;
      state_reg.stage2 <= pfs_pkg::SYNC_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign q = state_reg.stage2;

endmodule

`default_nettype wire
